// >>> dv/clptm_geom_model.sv
// Geometry stage model presenting one object per request
`timescale 1ns/10ps
module clptm_geom_model (
	// Clock and reset
	input wire clock,
	input wire srst,
	// Request
	input wire send,
	input wire [64:0] pkt,
	// Object out
	output reg obj_valid,
	output reg [64:0] obj
);
	// Fields are scrambled outside the valid cycle
	always @(posedge clock) begin
		obj_valid <= send && !srst;
		obj <= send ? pkt : ~obj;
	end
endmodule // clptm_geom_model

// >>> dv/clptm_top_properties.sv
// Checker for routing, provoking vertex and configuration outputs
`timescale 1ns/10ps
module clptm_props (
	// Clock and reset
	input wire clock,
	input wire srst,
	// Register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_write,
	// Object in
	input wire obj_valid,
	input wire obj_is_point,
	input wire obj_is_line,
	input wire obj_is_fan,
	input wire obj_has_adj,
	input wire [2:0] vtx_bad,
	// Results
	input wire near_plane_at_zero,
	input wire position_screen_space,
	input wire out_valid,
	input wire [1:0] out_disp,
	input wire [1:0] out_provoking,
	input wire out_adj_stripped
);
	reg [31:0] ctrl;
	reg [31:0] mode;
	reg [1:0] quiet;
	wire [2:0] cm = mode[15:13];
	wire [1:0] lsel = mode[3:2];
	wire [1:0] tsel = mode[5:4];
	wire live = obj_valid && cm[2:1] != 2'h3;
	// Shadow of control and mode, and cycles since a control write
	always @(posedge clock) begin
		if (srst) begin
			ctrl <= 32'h0;
			mode <= 32'h0;
			quiet <= 2'h0;
		end else begin
			if (reg_write && reg_addr == 4'h0)
				ctrl <= reg_wdata;
			if (reg_write && reg_addr == 4'h1)
				mode <= reg_wdata;
			quiet <= (reg_write && reg_addr == 4'h0) ? 2'h0 : (quiet == 2'h2 ? quiet : quiet + 2'h1);
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	AST_THREAD_ALL: assert property (obj_valid && cm == 3'h1 |=> out_valid && out_disp == 2'h1)
		else $error("object not sent to thread");
	AST_DROP_ALL: assert property (obj_valid && cm == 3'h3 |=> out_valid && out_disp == 2'h3)
		else $error("object not discarded");
	AST_RESV: assert property (obj_valid && cm[2:1] == 2'h3 |=> !out_valid)
		else $error("reserved mode produced output");
	AST_BAD: assert property (obj_valid && vtx_bad != 3'h0 && (cm == 3'h0 || cm == 3'h2 || cm == 3'h4)
		|=> out_valid && out_disp == 2'h3)
		else $error("bad object not discarded");
	AST_ADJ: assert property (obj_valid && obj_has_adj && cm == 3'h4 && vtx_bad == 3'h0 |=> out_disp == 2'h0 && out_adj_stripped)
		else $error("adjacency not stripped");
	AST_CAUSE: assert property (out_valid |-> $past(live))
		else $error("output without object");
	AST_CFG: assert property (quiet == 2'h2 |-> near_plane_at_zero == !ctrl[30] && position_screen_space == ctrl[29])
		else $error("config outputs wrong");
	AST_LINE: assert property (live && obj_is_line && !lsel[1] |=> out_provoking == $past(lsel))
		else $error("line provoking vertex wrong");
	AST_TRI: assert property (live && !obj_is_line && !obj_is_fan && !obj_is_point && tsel != 2'h3
		|=> out_provoking == $past(tsel))
		else $error("triangle provoking vertex wrong");
endmodule // clptm_props
bind clptm_top clptm_props u_props (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .obj_valid(obj_valid), .obj_is_point(obj_is_point), .obj_is_line(obj_is_line),
	.obj_is_fan(obj_is_fan), .obj_has_adj(obj_has_adj), .vtx_bad(vtx_bad), .near_plane_at_zero(near_plane_at_zero),
	.position_screen_space(position_screen_space), .out_valid(out_valid), .out_disp(out_disp),
	.out_provoking(out_provoking), .out_adj_stripped(out_adj_stripped));

// >>> dv/testbench.sv
// Self-checking bench for clip test mode control
`timescale 1ns/10ps
module testbench;
	reg clock = 1'b0;
	reg srst = 1'b1;
	reg [3:0] reg_addr = 4'h0;
	reg [31:0] reg_wdata = 32'h0;
	reg reg_write = 1'b0;
	reg reg_read = 1'b0;
	reg send = 1'b0;
	reg [64:0] pkt = 65'h0;
	reg [64:0] pk [0:3];
	wire [31:0] reg_rdata;
	wire obj_valid;
	wire [64:0] obj;
	wire np, ss, ov, adj;
	wire [1:0] disp, prov;
	integer n_errors = 0;
	integer n_compared = 0;
	integer m, c, k;
	reg [1:0] d;
	always #2 clock = ~clock;
	clptm_geom_model u_geom (.clock(clock), .srst(srst), .send(send), .pkt(pkt), .obj_valid(obj_valid), .obj(obj));
	clptm_top u_dut (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .obj_valid(obj_valid), .obj_is_point(obj[64]), .obj_is_line(obj[63]),
		.obj_is_fan(obj[62]), .obj_has_adj(obj[61]), .obj_geom_prim(obj[60]), .vtx_bad(obj[59:57]),
		.negative_w_outcode(obj[56:54]), .vtx_vpxy_out(obj[53:42]), .vtx_gb_out(obj[41:30]), .vtx_vpz_out(obj[29:24]),
		.user_plane_flags(obj[23:0]), .near_plane_at_zero(np), .position_screen_space(ss), .out_valid(ov),
		.out_disp(disp), .out_provoking(prov), .out_adj_stripped(adj));
	task wrap_up;
		begin
			$display("errors=%0d compared=%0d", n_errors, n_compared);
			if (n_errors == 0 && n_compared > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] v);
		begin
			@(posedge clock);
			reg_addr <= a;
			reg_wdata <= v;
			reg_write <= 1'b1;
			@(posedge clock);
			reg_write <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, input [31:0] e);
		begin
			@(posedge clock);
			reg_addr <= a;
			reg_read <= 1'b1;
			@(posedge clock);
			reg_read <= 1'b0;
			#1 chk(reg_rdata, e);
		end
	endtask
	// e[5] set means no output expected, else {adj, provoking, disposition}
	task send_obj(input [64:0] p, input [5:0] e);
		begin
			@(posedge clock);
			pkt <= p;
			send <= 1'b1;
			@(posedge clock);
			send <= 1'b0;
			for (k = 0; k < 3 && ov !== 1'b1; k = k + 1) begin
				@(posedge clock);
				#1;
			end
			if (e[5])
				chk(ov, 1'b0);
			else if (ov !== 1'b1) begin
				n_errors = n_errors + 1;
				wrap_up;
			end else
				chk({disp == 2'h0 ? adj : 1'b0, prov, disp}, e[4:0]);
		end
	endtask
	initial begin
		pk[0] = 65'h3000_0000_0000_0000;
		pk[1] = 65'h0200_0000_0000_0000;
		pk[2] = 65'h0000_0400_0000_0000;
		pk[3] = 65'h0004_4400_0000_0000;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		#1 chk(np, 1'b1);
		chk(ss, 1'b0);
		rd(4'h2, 32'h0);
		wr(4'h0, 32'h7000_0200);
		repeat (2) @(posedge clock);
		#1 chk({np, ss}, 2'h1);
		send_obj(pk[0], 6'h10);
		rd(4'h2, 32'h1);
		wr(4'h0, 32'h1000_0000);
		send_obj(pk[0], 6'h10);
		rd(4'h2, 32'h1);
		wr(4'h3, 32'h0000_00FF);
		rd(4'h3, 32'h2);
		rd(4'h9, 32'h0);
		wr(4'h2, 32'h0000_00FF);
		rd(4'h2, 32'h0000_00FF);
		for (m = 0; m < 8; m = m + 1) begin
			wr(4'h1, (m << 13) | 32'h20);
			for (c = 0; c < 4; c = c + 1) begin
				d = 48'hCF7_4D6_FF7_0D4 >> (c * 12 + m * 2);
				send_obj(pk[c], m > 5 ? 6'h20 : {1'b0, c == 0 && d == 2'h0, 2'h2, d});
			end
		end
		wr(4'h1, 32'h0000_0006);
		send_obj(65'h8000_0000_0000_0000, 6'h04);
		send_obj(65'h4000_0000_0000_0000, 6'h08);
		wr(4'h1, 32'h0000_000C);
		send_obj(65'h8000_0000_0000_0000, 6'h00);
		wr(4'h0, 32'h1101_0000);
		send_obj(65'h1, 6'h02);
		wr(4'h0, 32'h1102_0000);
		send_obj(65'h1, 6'h00);
		wr(4'h0, 32'h0400_0000);
		send_obj(65'h0000_0000_4000_0000, 6'h02);
		send_obj(65'h1_0000_0000_4000_0000, 6'h00);
		wr(4'h0, 32'h1000_0000);
		send_obj(65'h0000_0000_4000_0000, 6'h00);
		wr(4'h0, 32'h0000_0000);
		send_obj(65'h0000_0400_0000_0000, 6'h00);
		wr(4'h0, 32'h0800_0000);
		send_obj(65'h0000_0000_0100_0000, 6'h02);
		send_obj(65'h0000_0000_1500_0000, 6'h03);
		wr(4'h0, 32'h0200_0000);
		send_obj(65'h0040_0000_0000_0000, 6'h02);
		send_obj(65'h01C0_0000_0000_0000, 6'h03);
		wrap_up;
	end
endmodule // testbench

// >>> hdl/clptm_top.v
// Clip test mode control: classification, routing, provoking vertex, counter
`timescale 1ns/10ps
`include "clptm_map.vh"
module clptm_top #(
	parameter NUM_PLANES = 8,
	parameter COUNT_WIDTH = 32,
	parameter HW_CLIPPER = 1
) (
	// Clock and reset
	input wire clock,
	input wire srst,
	// Register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [31:0] reg_rdata,
	// Object from geometry stage, outcodes per vertex (3 vertices)
	input wire obj_valid,
	input wire obj_is_point,
	input wire obj_is_line,
	input wire obj_is_fan,
	input wire obj_has_adj,
	input wire obj_geom_prim,
	input wire [2:0] vtx_bad,
	input wire [2:0] negative_w_outcode,
	input wire [11:0] vtx_vpxy_out,
	input wire [11:0] vtx_gb_out,
	input wire [5:0] vtx_vpz_out,
	input wire [3*NUM_PLANES-1:0] user_plane_flags,
	// Configuration to vertex outcode test
	output reg near_plane_at_zero,
	output reg position_screen_space,
	// Routing result
	output reg out_valid,
	output reg [1:0] out_disp,
	output reg [1:0] out_provoking,
	output reg out_adj_stripped
);
	// Stored configuration and counters
	reg [31:0] ctrl;
	reg [31:0] mode;
	reg [COUNT_WIDTH-1:0] geom_output_prim_counter;
	reg [31:0] obj_total;

	// Decoded configuration
	wire cfg_stats_en;
	wire cfg_near_minus_one;
	wire cfg_screen_space;
	wire cfg_vpxy_en;
	wire cfg_vpz_en;
	wire cfg_gb_en;
	wire cfg_negative_w_outcode_en;
	wire cfg_umc_en;
	wire [NUM_PLANES-1:0] umask;
	wire [2:0] cmode;
	wire [1:0] tri_sel;
	wire [1:0] line_sel;
	wire [1:0] fan_sel;

	// Register port decode
	wire wr_ctrl;
	wire wr_mode;
	wire wr_count;

	// Classification
	reg [3:0] xy_v0;
	reg [3:0] xy_v1;
	reg [3:0] xy_v2;
	reg [3:0] rej_bits;
	reg [3:0] acc_bits;
	reg z_any;
	reg z_all;
	reg w_any;
	reg w_all;
	reg [NUM_PLANES-1:0] up_v0;
	reg [NUM_PLANES-1:0] up_v1;
	reg [NUM_PLANES-1:0] up_v2;
	reg [2:0] v_out;
	reg u_all_out;
	reg any_bad;
	reg f_reject;
	reg f_accept;
	reg u_straddle;
	reg f_clean;

	// Routing, provoking vertex and register next values
	reg [1:0] next_disp;
	reg next_pass;
	reg [1:0] next_prov;
	reg [COUNT_WIDTH-1:0] next_count;
	reg [31:0] next_rdata;

	assign cfg_stats_en = ctrl[`CLPTM_BIT_STATS];
	assign cfg_near_minus_one = ctrl[`CLPTM_BIT_API];
	assign cfg_screen_space = ctrl[`CLPTM_BIT_VPOS];
	assign cfg_vpxy_en = ctrl[`CLPTM_BIT_VPXY];
	assign cfg_vpz_en = ctrl[`CLPTM_BIT_VPZ];
	assign cfg_gb_en = ctrl[`CLPTM_BIT_GB];
	assign cfg_negative_w_outcode_en = ctrl[`CLPTM_BIT_NEGATIVE_W_OUTCODE];
	assign cfg_umc_en = ctrl[`CLPTM_BIT_UMC];
	assign umask = ctrl[`CLPTM_UMASK_HI:`CLPTM_UMASK_LO];
	assign cmode = mode[`CLPTM_MODE_HI:`CLPTM_MODE_LO];
	assign tri_sel = mode[`CLPTM_TRI_HI:`CLPTM_TRI_LO];
	assign line_sel = mode[`CLPTM_LINE_HI:`CLPTM_LINE_LO];
	assign fan_sel = mode[`CLPTM_FAN_HI:`CLPTM_FAN_LO];
	assign wr_ctrl = reg_write && (reg_addr == `CLPTM_REG_CTRL);
	assign wr_mode = reg_write && (reg_addr == `CLPTM_REG_MODE);
	assign wr_count = reg_write && (reg_addr == `CLPTM_REG_COUNT);

	// One vertex: XY outcode with guardband/viewport substitution
	function [3:0] xy_code;
		input vpxy_en;
		input gb_en;
		input is_point;
		input [3:0] vp;
		input [3:0] gb;
		begin
			if (gb_en && !is_point) begin
				xy_code = gb;
			end else if (vpxy_en) begin
				xy_code = vp;
			end else begin
				xy_code = 4'h0;
			end
		end
	endfunction

	// Provoking vertex index; codes above the limit fall back to vertex 0
	function [1:0] prov_pick;
		input [1:0] sel;
		input [1:0] limit;
		begin
			if (sel > limit) begin
				prov_pick = 2'h0;
			end else begin
				prov_pick = sel;
			end
		end
	endfunction

	// Disposition by classification: discard, pass when clean, else clip
	function [1:0] class_route;
		input drop;
		input clean;
		input [1:0] clip_disp;
		begin
			if (drop) begin
				class_route = `CLPTM_DISP_DISCARD;
			end else if (clean) begin
				class_route = `CLPTM_DISP_PASS;
			end else begin
				class_route = clip_disp;
			end
		end
	endfunction

	// XY outcodes per vertex and their summaries
	always @* begin
		xy_v0 = xy_code(cfg_vpxy_en, cfg_gb_en, obj_is_point, vtx_vpxy_out[3:0], vtx_gb_out[3:0]);
		xy_v1 = xy_code(cfg_vpxy_en, cfg_gb_en, obj_is_point, vtx_vpxy_out[7:4], vtx_gb_out[7:4]);
		xy_v2 = xy_code(cfg_vpxy_en, cfg_gb_en, obj_is_point, vtx_vpxy_out[11:8], vtx_gb_out[11:8]);
		rej_bits = xy_v0 & xy_v1 & xy_v2;
		acc_bits = xy_v0 | xy_v1 | xy_v2;
	end

	// Depth and negative-w outcodes
	always @* begin
		z_any = 1'b0;
		z_all = 1'b0;
		w_any = 1'b0;
		w_all = 1'b0;
		if (cfg_vpz_en) begin
			z_any = |vtx_vpz_out;
			z_all = (vtx_vpz_out[0] & vtx_vpz_out[2] & vtx_vpz_out[4]) |
				(vtx_vpz_out[1] & vtx_vpz_out[3] & vtx_vpz_out[5]);
		end
		if (cfg_negative_w_outcode_en) begin
			w_any = |negative_w_outcode;
			w_all = &negative_w_outcode;
		end
	end

	// Masked user plane flags
	always @* begin
		up_v0 = user_plane_flags[NUM_PLANES-1:0] & umask;
		up_v1 = user_plane_flags[2*NUM_PLANES-1:NUM_PLANES] & umask;
		up_v2 = user_plane_flags[3*NUM_PLANES-1:2*NUM_PLANES] & umask;
		v_out = {|up_v2, |up_v1, |up_v0};
		u_all_out = |(up_v0 & up_v1 & up_v2);
	end

	// Object classification
	always @* begin
		any_bad = |vtx_bad;
		f_reject = (rej_bits != 4'h0) || z_all || w_all || u_all_out;
		f_accept = (acc_bits == 4'h0) && !z_any && !w_any;
		u_straddle = cfg_umc_en && (v_out != 3'h0) && !f_reject;
		f_clean = f_accept && !u_straddle;
	end

	// Routing by clip mode
	always @* begin
		next_pass = 1'b1;
		case (cmode)
			3'h0: begin
				if (HW_CLIPPER != 0) begin
					next_disp = class_route(any_bad || f_reject, f_clean, `CLPTM_DISP_HWCLIP);
				end else begin
					next_disp = class_route(any_bad || f_reject, f_clean, `CLPTM_DISP_THREAD);
				end
			end
			3'h1: begin
				next_disp = `CLPTM_DISP_THREAD;
			end
			3'h2: begin
				next_disp = class_route(any_bad || f_reject, 1'b0, `CLPTM_DISP_THREAD);
			end
			3'h3: begin
				next_disp = `CLPTM_DISP_DISCARD;
			end
			3'h4: begin
				next_disp = class_route(any_bad, 1'b1, `CLPTM_DISP_PASS);
			end
			3'h5: begin
				next_disp = class_route(any_bad || f_reject, f_clean, `CLPTM_DISP_THREAD);
			end
			default: begin
				next_disp = `CLPTM_DISP_DISCARD;
				next_pass = 1'b0;
			end
		endcase
	end

	// Provoking vertex by primitive kind
	always @* begin
		if (obj_is_line) begin
			next_prov = prov_pick(line_sel, 2'h1);
		end else if (obj_is_fan) begin
			next_prov = prov_pick(fan_sel, 2'h2);
		end else begin
			next_prov = prov_pick(tri_sel, 2'h2);
		end
	end

	// Counter next value; a software write beats an increment
	always @* begin
		next_count = geom_output_prim_counter;
		if (wr_count) begin
			next_count = reg_wdata[COUNT_WIDTH-1:0];
		end else if (obj_valid && obj_geom_prim && cfg_stats_en) begin
			next_count = geom_output_prim_counter + 1'b1;
		end
	end

	// Read data next value
	always @* begin
		next_rdata = 32'h00000000;
		if (reg_read) begin
			if (reg_addr == `CLPTM_REG_CTRL) begin
				next_rdata = ctrl;
			end else if (reg_addr == `CLPTM_REG_MODE) begin
				next_rdata = mode;
			end else if (reg_addr == `CLPTM_REG_COUNT) begin
				next_rdata[COUNT_WIDTH-1:0] = geom_output_prim_counter;
			end else if (reg_addr == `CLPTM_REG_STATUS) begin
				next_rdata = obj_total;
			end
		end
	end

	// Control register; clearing the stats bit is left to software
	always @(posedge clock) begin
		if (srst) begin
			ctrl <= `CLPTM_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= reg_wdata;
		end
	end

	// Mode register
	always @(posedge clock) begin
		if (srst) begin
			mode <= `CLPTM_MODE_RESET;
		end else if (wr_mode) begin
			mode <= reg_wdata;
		end
	end

	// Geometry output primitive counter
	always @(posedge clock) begin
		if (srst) begin
			geom_output_prim_counter <= {COUNT_WIDTH{1'b0}};
		end else begin
			geom_output_prim_counter <= next_count;
		end
	end

	// Total objects seen
	always @(posedge clock) begin
		if (srst) begin
			obj_total <= 32'h00000000;
		end else if (obj_valid) begin
			obj_total <= obj_total + 32'h00000001;
		end
	end

	// Read data, one cycle after the strobe
	always @(posedge clock) begin
		if (srst) begin
			reg_rdata <= 32'h00000000;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// Near plane choice for the outcode test
	always @(posedge clock) begin
		if (srst) begin
			near_plane_at_zero <= 1'b1;
		end else begin
			near_plane_at_zero <= ~cfg_near_minus_one;
		end
	end

	// Position space for the outcode test
	always @(posedge clock) begin
		if (srst) begin
			position_screen_space <= 1'b0;
		end else begin
			position_screen_space <= cfg_screen_space;
		end
	end

	// Result valid
	always @(posedge clock) begin
		if (srst) begin
			out_valid <= 1'b0;
		end else begin
			out_valid <= obj_valid & next_pass;
		end
	end

	// Disposition
	always @(posedge clock) begin
		if (srst) begin
			out_disp <= 2'h0;
		end else begin
			out_disp <= next_disp;
		end
	end

	// Provoking vertex
	always @(posedge clock) begin
		if (srst) begin
			out_provoking <= 2'h0;
		end else begin
			out_provoking <= next_prov;
		end
	end

	// Adjacency removal flag
	always @(posedge clock) begin
		if (srst) begin
			out_adj_stripped <= 1'b0;
		end else begin
			out_adj_stripped <= obj_valid & obj_has_adj;
		end
	end
endmodule // clptm_top

// >>> inc/clptm_map.vh
// Constants for the clip test mode control block
// Operation
// - Stats enable bit counts geometry output primitives
// - API mode bit picks near plane zero/minus-one
// - Position space bit: normalized or screen space
// - Viewport XY enable gates X/Y comparisons
// - Viewport Z enable gates near/far comparisons
// - Guardband enable tests XY for non-points only
// - Guardband off, viewport on: guardband equals viewport
// - Both XY tests off: vertex visible in XY
// - Negative-w enable gates w=0 plane outcode
// - User must-clip: straddling user planes block trivial accept
// - User must-clip off: flags only accept/reject
// - Eight-bit mask selects participating user flags
// - Mode 0: accept downstream, reject discard, clip
// - Mode 1: every object goes to thread
// - Mode 2: accept and clip to thread
// - Mode 3: discard every object
// - Mode 4: all but bad objects accepted
// - Adjacency always stripped before setup stage
// - Mode 5 forces thread clip; 6-7 reserved
// - Triangle strip/list provoking vertex select
// - Line strip/list provoking vertex select
// - Triangle fan provoking vertex select
`ifndef CLPTM_MAP_VH
`define CLPTM_MAP_VH
`define CLPTM_REG_CTRL 4'h0
`define CLPTM_REG_MODE 4'h1
`define CLPTM_REG_COUNT 4'h2
`define CLPTM_REG_STATUS 4'h3
`define CLPTM_BIT_STATS 9
`define CLPTM_BIT_API 30
`define CLPTM_BIT_VPOS 29
`define CLPTM_BIT_VPXY 28
`define CLPTM_BIT_VPZ 27
`define CLPTM_BIT_GB 26
`define CLPTM_BIT_NEGATIVE_W_OUTCODE 25
`define CLPTM_BIT_UMC 24
`define CLPTM_UMASK_HI 23
`define CLPTM_UMASK_LO 16
`define CLPTM_MODE_HI 15
`define CLPTM_MODE_LO 13
`define CLPTM_TRI_HI 5
`define CLPTM_TRI_LO 4
`define CLPTM_LINE_HI 3
`define CLPTM_LINE_LO 2
`define CLPTM_FAN_HI 1
`define CLPTM_FAN_LO 0
`define CLPTM_CTRL_RESET 32'h00000000
`define CLPTM_MODE_RESET 32'h00000000
`define CLPTM_DISP_PASS 2'h0
`define CLPTM_DISP_THREAD 2'h1
`define CLPTM_DISP_HWCLIP 2'h2
`define CLPTM_DISP_DISCARD 2'h3
`endif
